// ===== logic/srs_pkg.sv
// Register map, field layout and reset values of the system remap,
// status and oscillator control bank.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package srs_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int SRS_DATA_W = 32;
    localparam int SRS_ADDR_W = 34;
    localparam int SRS_SEL_W = 4;
    localparam int SRS_REG_W = 16;
    localparam int SRS_IDX_W = 32;
    localparam int SRS_LANE_W = 8;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [SRS_IDX_W-1:0] SRS_IDX_SYS_CTRL = 32'h5000_0012;
    localparam logic [SRS_IDX_W-1:0] SRS_IDX_SYS_STAT = 32'h5000_0014;
    localparam logic [SRS_IDX_W-1:0] SRS_IDX_CLK_SLOW = 32'h5000_0020;
    localparam logic [SRS_IDX_W-1:0] SRS_IDX_CLK_FAST = 32'h5000_0022;
    localparam logic [SRS_IDX_W-1:0] SRS_IDX_CLK_LOWF = 32'h5000_0024;

    // ------------------------------------------------------------------
    // System control fields
    // ------------------------------------------------------------------
    localparam int SRS_BOOT_MAP_LSB = 0;
    localparam int SRS_BOOT_MAP_W = 3;
    localparam int SRS_RAM_ORDER_LSB = 3;
    localparam int SRS_RAM_ORDER_W = 2;
    localparam int SRS_CACHE_ROUTE_BIT = 10;
    localparam logic [15:0] SRS_SYS_CTRL_RST = 16'h0000;
    localparam logic [15:0] SRS_SYS_CTRL_WMASK = 16'h041f;

    // Boot map codes
    localparam logic [2:0] SRS_MAP_ROM = 3'h0;
    localparam logic [2:0] SRS_MAP_OTP = 3'h1;
    localparam logic [2:0] SRS_MAP_FLASH = 3'h2;
    localparam logic [2:0] SRS_MAP_RAMS = 3'h3;
    localparam logic [2:0] SRS_MAP_FLASH_UNC = 3'h4;
    localparam logic [2:0] SRS_MAP_OTP_UNC = 3'h5;
    localparam logic [2:0] SRS_MAP_CACHE_RAM = 3'h6;
    localparam int SRS_TARGET_W = 7;
    localparam logic [6:0] SRS_TARGET_NONE = 7'h00;
    localparam logic [6:0] SRS_TARGET_ONE = 7'h01;

    // ------------------------------------------------------------------
    // System status bits
    // ------------------------------------------------------------------
    localparam int SRS_ST_LINK_ON = 9;
    localparam int SRS_ST_LINK_OFF = 8;
    localparam int SRS_ST_TRIM_DONE = 6;
    localparam int SRS_ST_DEBUGGER = 5;
    localparam int SRS_ST_PERIPH_ON = 3;
    localparam int SRS_ST_PERIPH_OFF = 2;
    localparam int SRS_ST_RADIO_ON = 1;
    localparam int SRS_ST_RADIO_OFF = 0;
    localparam int SRS_ST_RSVD_ONE = 10;
    localparam logic [15:0] SRS_SYS_STAT_RST = 16'h0545;

    // ------------------------------------------------------------------
    // Slow (32 kHz) clock control fields
    // ------------------------------------------------------------------
    localparam int SRS_SX_AMPREG_OFF_BIT = 12;
    localparam int SRS_SRC_TRIM_LSB = 8;
    localparam int SRS_SRC_TRIM_W = 4;
    localparam int SRS_SRC_ON_BIT = 7;
    localparam int SRS_SX_CUR_LSB = 3;
    localparam int SRS_SX_CUR_W = 4;
    localparam int SRS_SX_RBIAS_LSB = 1;
    localparam int SRS_SX_RBIAS_W = 2;
    localparam int SRS_SX_ON_BIT = 0;
    localparam logic [15:0] SRS_CLK_SLOW_RST = 16'h079c;
    localparam logic [15:0] SRS_CLK_SLOW_WMASK = 16'h1fff;

    // ------------------------------------------------------------------
    // Fast (16 MHz) clock control fields
    // ------------------------------------------------------------------
    localparam int SRS_FX_HPASS_BIT = 14;
    localparam int SRS_FX_SPIKE_BIT = 13;
    localparam int SRS_FX_AMP_LSB = 10;
    localparam int SRS_FX_AMP_W = 3;
    localparam int SRS_FX_CUR_LSB = 5;
    localparam int SRS_FX_CUR_W = 3;
    localparam int SRS_FRC_TRIM_LSB = 1;
    localparam int SRS_FRC_TRIM_W = 4;
    localparam int SRS_FRC_ON_BIT = 0;
    localparam logic [15:0] SRS_CLK_FAST_RST = 16'h0c00;
    localparam logic [15:0] SRS_CLK_FAST_WMASK = 16'h7cff;

    // ------------------------------------------------------------------
    // Low-frequency RC control fields
    // ------------------------------------------------------------------
    localparam int SRS_LRC_ON_BIT = 11;
    localparam int SRS_LRC_LOW_BIT = 10;
    localparam int SRS_LRC_BIAS_LSB = 8;
    localparam int SRS_LRC_BIAS_W = 2;
    localparam int SRS_LRC_TEMP_LSB = 4;
    localparam int SRS_LRC_TEMP_W = 4;
    localparam int SRS_LRC_TRIM_LSB = 0;
    localparam int SRS_LRC_TRIM_W = 4;
    localparam logic [15:0] SRS_CLK_LOWF_RST = 16'h0178;
    localparam logic [15:0] SRS_CLK_LOWF_WMASK = 16'h0fff;

endpackage : srs_pkg

// ===== logic/srs_sys_osc_regs.sv
// Control and status register bank of the system and clock unit:
// boot remap selector, power-domain status and oscillator settings.
// Assumes a classic Wishbone master on clk_i and status inputs that
// are already synchronous to clk_i.

// Operation
// R1: Selector codes 0,1,2 map ROM, OTP, cached flash at address zero.
// R2: Code 3 maps data RAMs at zero, ordered by the RAM order field.
// R3: Codes 4 and 5 map uncached flash and uncached OTP at zero.
// R4: Code 6 maps cache data RAM only while the cache is bypassed.
// R5: Software uses only 8, 16 or 32-bit accesses to mirrored cache RAM.
// R6: Software avoids DMA to cache data RAM while code 6 is selected.
// R7: Status bits 9 and 8 show link debug domain up and down.
// R8: Status bits 3 and 2 show peripheral domain up and down.
// R9: Status bits 1 and 0 show radio domain up and down.
// R10: Status bit 6 shows fast crystal trim settled, reset value 1.
// R11: Status bit 5 shows a debugger is attached.
// R12: Software sets bit 12 only when an external clock drives input.
// R13: Slow RC trim in bits 11:8, reset 0111.
// R14: Bit 7 enables slow RC oscillator, reset 1.
// R15: Slow crystal bias current in bits 6:3, reset 0011.
// R16: Slow crystal bias resistor in bits 2:1, reset 10.
// R17: Bit 0 enables slow crystal oscillator, reset 0.
// R18: Fast register bit 14 high-pass enable, bit 13 spike bypass.
// R19: Fast crystal amplitude in bits 12:10, reset 3.
// R20: Fast crystal start-up current in bits 7:5, reset 0.
// R21: Fast RC enable bit 0 and trim bits 4:1, both reset 0.
// R22: Low-frequency RC enable, extra-low, bias, temperature and trim.
// R23: Reserved bits keep reset values; writable fields read back writes.
module srs_sys_osc_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [srs_pkg::SRS_ADDR_W-1:0] adr_i,
    input wire logic [srs_pkg::SRS_SEL_W-1:0] sel_i,
    input wire logic [srs_pkg::SRS_DATA_W-1:0] dat_i,
    output logic ack_o,
    output logic [srs_pkg::SRS_DATA_W-1:0] dat_o,
    input wire logic link_domain_on_i,
    input wire logic link_domain_off_i,
    input wire logic periph_domain_on_i,
    input wire logic periph_domain_off_i,
    input wire logic radio_domain_on_i,
    input wire logic radio_domain_off_i,
    input wire logic fast_xtal_trim_done_i,
    input wire logic debugger_attached_i,
    output logic [srs_pkg::SRS_BOOT_MAP_W-1:0] boot_map_select_o,
    output logic [srs_pkg::SRS_RAM_ORDER_W-1:0] ram_order_select_o,
    output logic cache_ram_route_o,
    output logic [srs_pkg::SRS_TARGET_W-1:0] boot_target_o,
    output logic slow_xtal_ampreg_off_o,
    output logic [srs_pkg::SRS_SRC_TRIM_W-1:0] slow_rc_trim_o,
    output logic slow_rc_on_o,
    output logic [srs_pkg::SRS_SX_CUR_W-1:0] slow_xtal_bias_current_o,
    output logic [srs_pkg::SRS_SX_RBIAS_W-1:0] slow_xtal_bias_resistor_o,
    output logic slow_xtal_on_o,
    output logic fast_xtal_highpass_on_o,
    output logic fast_xtal_spike_bypass_o,
    output logic [srs_pkg::SRS_FX_AMP_W-1:0] fast_xtal_amplitude_o,
    output logic [srs_pkg::SRS_FX_CUR_W-1:0] fast_xtal_startup_current_o,
    output logic [srs_pkg::SRS_FRC_TRIM_W-1:0] fast_rc_trim_o,
    output logic fast_rc_on_o,
    output logic lowfreq_rc_on_o,
    output logic lowfreq_rc_extra_low_o,
    output logic [srs_pkg::SRS_LRC_BIAS_W-1:0] lowfreq_rc_bias_o,
    output logic [srs_pkg::SRS_LRC_TEMP_W-1:0] lowfreq_rc_temp_ctrl_o,
    output logic [srs_pkg::SRS_LRC_TRIM_W-1:0] lowfreq_rc_trim_o
);
    import srs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [SRS_DATA_W-1:0] dat;
        logic [SRS_REG_W-1:0] sys_ctrl;
        logic [SRS_REG_W-1:0] sys_stat;
        logic [SRS_REG_W-1:0] clk_slow;
        logic [SRS_REG_W-1:0] clk_fast;
        logic [SRS_REG_W-1:0] clk_lowf;
        logic [SRS_TARGET_W-1:0] target;
    } srs_state_s;

    localparam srs_state_s SRS_STATE_RST = '{
        ack: 1'b0,
        dat: '0,
        sys_ctrl: SRS_SYS_CTRL_RST,
        sys_stat: SRS_SYS_STAT_RST,
        clk_slow: SRS_CLK_SLOW_RST,
        clk_fast: SRS_CLK_FAST_RST,
        clk_lowf: SRS_CLK_LOWF_RST,
        target: SRS_TARGET_ONE
    };

    srs_state_s st;
    srs_state_s next_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Only lanes 0 and 1 carry register bits; upper lanes are ignored.
    function automatic logic [SRS_REG_W-1:0] merge_write(
        input logic [SRS_REG_W-1:0] old_val,
        input logic [SRS_DATA_W-1:0] wdat,
        input logic [SRS_SEL_W-1:0] sel,
        input logic [SRS_REG_W-1:0] wmask
    );
        logic [SRS_REG_W-1:0] lane_mask;
        lane_mask = {{SRS_LANE_W{sel[1]}}, {SRS_LANE_W{sel[0]}}} & wmask;
        return (old_val & ~lane_mask) | (wdat[SRS_REG_W-1:0] & lane_mask);
    endfunction : merge_write

    // One-hot memory at address zero; none for illegal combinations.
    function automatic logic [SRS_TARGET_W-1:0] decode_target(
        input logic [SRS_BOOT_MAP_W-1:0] code,
        input logic route
    );
        logic [SRS_TARGET_W-1:0] t;
        t = SRS_TARGET_NONE;
        if (code == SRS_MAP_ROM || code == SRS_MAP_OTP ||
            code == SRS_MAP_FLASH) begin
            t = SRS_TARGET_ONE << code; // R1
        end else if (code == SRS_MAP_RAMS) begin
            t = SRS_TARGET_ONE << code; // R2
        end else if (code == SRS_MAP_FLASH_UNC ||
                     code == SRS_MAP_OTP_UNC) begin
            t = SRS_TARGET_ONE << code; // R3
        end else if (code == SRS_MAP_CACHE_RAM && !route) begin
            // Cache RAM only visible while the controller is bypassed
            t = SRS_TARGET_ONE << code; // R4
        end
        return t;
    endfunction : decode_target

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [SRS_IDX_W-1:0] word_idx;
    logic req;

    assign word_idx = adr_i[SRS_ADDR_W-1:2];
    assign req = cyc_i && stb_i && !st.ack;

    always_comb begin
        logic [SRS_REG_W-1:0] stat;
        logic [SRS_REG_W-1:0] rd;
        next_st = st;
        stat = '0;
        rd = '0;

        // Status sampled every cycle that ce_i is high; reserved bit 10 fixed at one
        stat[SRS_ST_RSVD_ONE] = 1'b1; // R23
        stat[SRS_ST_LINK_ON] = link_domain_on_i; // R7
        stat[SRS_ST_LINK_OFF] = link_domain_off_i; // R7
        stat[SRS_ST_PERIPH_ON] = periph_domain_on_i; // R8
        stat[SRS_ST_PERIPH_OFF] = periph_domain_off_i; // R8
        stat[SRS_ST_RADIO_ON] = radio_domain_on_i; // R9
        stat[SRS_ST_RADIO_OFF] = radio_domain_off_i; // R9
        stat[SRS_ST_TRIM_DONE] = fast_xtal_trim_done_i; // R10
        stat[SRS_ST_DEBUGGER] = debugger_attached_i; // R11
        next_st.sys_stat = stat;

        // Classic single cycle: ack one cycle after the request, then drop
        next_st.ack = req;
        if (req) begin
            if (word_idx == SRS_IDX_SYS_CTRL) begin
                rd = st.sys_ctrl;
                if (we_i) begin
                    next_st.sys_ctrl = merge_write(st.sys_ctrl, dat_i,
                        sel_i, SRS_SYS_CTRL_WMASK); // R23
                end
            end else if (word_idx == SRS_IDX_SYS_STAT) begin
                rd = st.sys_stat; // R7
            end else if (word_idx == SRS_IDX_CLK_SLOW) begin
                rd = st.clk_slow;
                if (we_i) begin
                    next_st.clk_slow = merge_write(st.clk_slow, dat_i,
                        sel_i, SRS_CLK_SLOW_WMASK); // R23
                end
            end else if (word_idx == SRS_IDX_CLK_FAST) begin
                rd = st.clk_fast;
                if (we_i) begin
                    next_st.clk_fast = merge_write(st.clk_fast, dat_i,
                        sel_i, SRS_CLK_FAST_WMASK); // R23
                end
            end else if (word_idx == SRS_IDX_CLK_LOWF) begin
                rd = st.clk_lowf;
                if (we_i) begin
                    next_st.clk_lowf = merge_write(st.clk_lowf, dat_i,
                        sel_i, SRS_CLK_LOWF_WMASK); // R23
                end
            end else begin
                // Unmapped: acknowledged, reads zero, writes dropped
                rd = '0;
            end
            next_st.dat = {{(SRS_DATA_W-SRS_REG_W){1'b0}}, rd};
        end

        // Map decodes the incoming selector, so it changes on the same edge as the write
        next_st.target = decode_target(
            next_st.sys_ctrl[SRS_BOOT_MAP_LSB +: SRS_BOOT_MAP_W],
            next_st.sys_ctrl[SRS_CACHE_ROUTE_BIT]); // R1
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= SRS_STATE_RST;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state flops
    // ------------------------------------------------------------------
    assign ack_o = st.ack;
    assign dat_o = st.dat;
    assign boot_map_select_o = st.sys_ctrl[SRS_BOOT_MAP_LSB +: SRS_BOOT_MAP_W];
    assign ram_order_select_o =
        st.sys_ctrl[SRS_RAM_ORDER_LSB +: SRS_RAM_ORDER_W]; // R2
    assign cache_ram_route_o = st.sys_ctrl[SRS_CACHE_ROUTE_BIT]; // R4
    assign boot_target_o = st.target;

    // Amplitude regulation bit is stored only; its use is up to software
    assign slow_xtal_ampreg_off_o = st.clk_slow[SRS_SX_AMPREG_OFF_BIT];
    assign slow_rc_trim_o =
        st.clk_slow[SRS_SRC_TRIM_LSB +: SRS_SRC_TRIM_W]; // R13
    assign slow_rc_on_o = st.clk_slow[SRS_SRC_ON_BIT]; // R14
    assign slow_xtal_bias_current_o =
        st.clk_slow[SRS_SX_CUR_LSB +: SRS_SX_CUR_W]; // R15
    assign slow_xtal_bias_resistor_o =
        st.clk_slow[SRS_SX_RBIAS_LSB +: SRS_SX_RBIAS_W]; // R16
    assign slow_xtal_on_o = st.clk_slow[SRS_SX_ON_BIT]; // R17

    assign fast_xtal_highpass_on_o = st.clk_fast[SRS_FX_HPASS_BIT]; // R18
    assign fast_xtal_spike_bypass_o = st.clk_fast[SRS_FX_SPIKE_BIT]; // R18
    assign fast_xtal_amplitude_o =
        st.clk_fast[SRS_FX_AMP_LSB +: SRS_FX_AMP_W]; // R19
    assign fast_xtal_startup_current_o =
        st.clk_fast[SRS_FX_CUR_LSB +: SRS_FX_CUR_W]; // R20
    assign fast_rc_trim_o =
        st.clk_fast[SRS_FRC_TRIM_LSB +: SRS_FRC_TRIM_W]; // R21
    assign fast_rc_on_o = st.clk_fast[SRS_FRC_ON_BIT]; // R21

    assign lowfreq_rc_on_o = st.clk_lowf[SRS_LRC_ON_BIT]; // R22
    assign lowfreq_rc_extra_low_o = st.clk_lowf[SRS_LRC_LOW_BIT]; // R22
    assign lowfreq_rc_bias_o =
        st.clk_lowf[SRS_LRC_BIAS_LSB +: SRS_LRC_BIAS_W]; // R22
    assign lowfreq_rc_temp_ctrl_o =
        st.clk_lowf[SRS_LRC_TEMP_LSB +: SRS_LRC_TEMP_W]; // R22
    assign lowfreq_rc_trim_o =
        st.clk_lowf[SRS_LRC_TRIM_LSB +: SRS_LRC_TRIM_W]; // R22

endmodule : srs_sys_osc_regs

// ===== verification/srs_sys_osc_regs_bench.sv
// Self-checking bench for the remap, status and oscillator bank.
// Assumes the checker is bound from its own file; bench is bus master.
module srs_sys_osc_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import srs_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0;
    logic [33:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, q;
    logic [7:0] st = 8'h56; // Matches status reset pattern
    wire ack;
    wire [31:0] rdat;
    wire [2:0] bm;
    wire [1:0] ro;
    wire cr;
    wire [6:0] tgt;
    wire [12:0] sf, ff;
    wire [11:0] lf;
    int err_count = 0, n_checks = 0;
    localparam logic [31:0] T_IDX [8] = '{SRS_IDX_SYS_CTRL, SRS_IDX_CLK_SLOW,
        SRS_IDX_CLK_FAST, SRS_IDX_CLK_LOWF, SRS_IDX_CLK_SLOW, SRS_IDX_CLK_FAST,
        SRS_IDX_SYS_STAT, 32'h5000_0026};
    localparam logic [3:0] T_SEL [8] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h2,
        4'h3, 4'h3};
    localparam logic [31:0] T_WD [8] = '{32'hffff, 32'hffff, 32'hffff,
        32'hffff, 32'h1234, 32'h0000, 32'hffff, 32'hffff};
    localparam logic [31:0] T_EXP [8] = '{32'h041f, 32'h1fff, 32'h7cff,
        32'h0fff, 32'h1f34, 32'h00ff, 32'h0545, 32'h0000};
    localparam int POS [8] = '{5, 6, 0, 1, 2, 3, 8, 9};
    srs_sys_osc_regs dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .ack_o(ack), .dat_o(rdat), .link_domain_on_i(st[7]),
        .link_domain_off_i(st[6]), .periph_domain_on_i(st[5]),
        .periph_domain_off_i(st[4]), .radio_domain_on_i(st[3]),
        .radio_domain_off_i(st[2]), .fast_xtal_trim_done_i(st[1]),
        .debugger_attached_i(st[0]), .boot_map_select_o(bm),
        .ram_order_select_o(ro), .cache_ram_route_o(cr), .boot_target_o(tgt),
        .slow_xtal_ampreg_off_o(sf[12]), .slow_rc_trim_o(sf[11:8]),
        .slow_rc_on_o(sf[7]), .slow_xtal_bias_current_o(sf[6:3]),
        .slow_xtal_bias_resistor_o(sf[2:1]), .slow_xtal_on_o(sf[0]),
        .fast_xtal_highpass_on_o(ff[12]), .fast_xtal_spike_bypass_o(ff[11]),
        .fast_xtal_amplitude_o(ff[10:8]), .fast_xtal_startup_current_o(ff[7:5]),
        .fast_rc_trim_o(ff[4:1]), .fast_rc_on_o(ff[0]),
        .lowfreq_rc_on_o(lf[11]), .lowfreq_rc_extra_low_o(lf[10]),
        .lowfreq_rc_bias_o(lf[9:8]), .lowfreq_rc_temp_ctrl_o(lf[7:4]),
        .lowfreq_rc_trim_o(lf[3:0]));
    always #5 clk = ~clk;
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // Holds the request until ack is sampled, then releases it
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_count++;
            summarize();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wait_ack
    task automatic wb(input logic w, input logic [31:0] idx,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= d;
        wait_ack();
    endtask : wb
    task automatic rd(input logic [31:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 4'h3, 32'h0);
        chk(q, exp);
    endtask : rd
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(SRS_IDX_SYS_CTRL, 32'h0000);
        rd(SRS_IDX_SYS_STAT, 32'h0545);
        rd(SRS_IDX_CLK_SLOW, 32'h079c);
        rd(SRS_IDX_CLK_FAST, 32'h0c00);
        rd(SRS_IDX_CLK_LOWF, 32'h0178);
        chk({25'h0, tgt}, 32'h01);
        chk({19'h0, sf}, 32'h079c);
        // Writes past each mask and byte lanes, then read back
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, T_IDX[i], T_SEL[i], T_WD[i]);
            rd(T_IDX[i], T_EXP[i]);
        end
        wb(1'b1, SRS_IDX_CLK_SLOW, 4'h3, 32'h1a5d);
        chk({19'h0, sf}, 32'h1a5d);
        wb(1'b1, SRS_IDX_CLK_FAST, 4'h3, 32'h54a7);
        chk({19'h0, ff}, 32'h15a7);
        rd(SRS_IDX_CLK_FAST, 32'h54a7);
        wb(1'b1, SRS_IDX_CLK_LOWF, 4'h3, 32'h0a3c);
        chk({20'h0, lf}, 32'h0a3c);
        // One status input at a time lands on its own bit
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            st <= 8'h01 << i;
            repeat (3) @(posedge clk);
            rd(SRS_IDX_SYS_STAT, 32'h0400 | (32'h1 << POS[i]));
        end
        st <= 8'h56;
        // Every selector code with both cache routes
        for (int c = 0; c < 16; c++) begin
            // Halfword (lanes 0 and 1) control writes only; no DMA path while code 6 is up
            wb(1'b1, SRS_IDX_SYS_CTRL, 4'h3,
                {21'h0, c[3], 5'h1f, c[1:0], c[2:0]});
            // Code 7, and code 6 behind the cache, map nothing
            chk({25'h0, tgt}, (c[2:0] == 3'h7 || (c[2:0] == 3'h6 && c[3])) ?
                32'h0 : 32'h1 << c[2:0]);
            chk({26'h0, cr, ro, bm}, {26'h0, c[3], c[1:0], c[2:0]});
        end
        // Clock enable low holds off the answer
        @(posedge clk);
        ce <= 1'b0;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= {SRS_IDX_CLK_LOWF, 2'b00};
        repeat (4) @(posedge clk);
        chk({31'h0, ack}, 32'h0);
        ce <= 1'b1;
        wait_ack();
        chk(q, 32'h0a3c);
        // Reset in mid-run restores defaults
        wb(1'b1, SRS_IDX_CLK_SLOW, 4'h3, 32'h0000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(SRS_IDX_CLK_SLOW, 32'h079c);
        chk({25'h0, tgt}, 32'h01);
        summarize();
    end
endmodule : srs_sys_osc_regs_bench

// ===== verification/srs_sys_osc_regs_props.sv
// Concurrent checks on the ports of the remap, status and oscillator bank.
// Assumes a single clock domain and the registered one-cycle ack.
module srs_sys_osc_regs_props
    import srs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [SRS_ADDR_W-1:0] adr_i,
    input wire logic link_domain_on_i,
    input wire logic link_domain_off_i,
    input logic ack_o,
    input logic [SRS_DATA_W-1:0] dat_o,
    input logic [SRS_BOOT_MAP_W-1:0] boot_map_select_o,
    input logic cache_ram_route_o,
    input logic [SRS_TARGET_W-1:0] boot_target_o,
    input logic slow_xtal_ampreg_off_o,
    input logic [SRS_SRC_TRIM_W-1:0] slow_rc_trim_o,
    input logic slow_rc_on_o,
    input logic [SRS_SX_CUR_W-1:0] slow_xtal_bias_current_o,
    input logic [SRS_SX_RBIAS_W-1:0] slow_xtal_bias_resistor_o,
    input logic slow_xtal_on_o,
    input logic [SRS_FX_AMP_W-1:0] fast_xtal_amplitude_o,
    input logic [SRS_LRC_TRIM_W-1:0] lowfreq_rc_trim_o
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam logic [33:0] ADR_STAT = {SRS_IDX_SYS_STAT, 2'b00};
    logic [6:0] exp_tgt;
    // Code 7 shifts out of range, so it maps nothing as well
    assign exp_tgt = (boot_map_select_o == 3'h6 && cache_ram_route_o) ?
                     7'h00 : (7'h01 << boot_map_select_o);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged in one cycle");
    a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_ce_freeze: assert property (!ce_i |=> $stable(ack_o) && $stable(dat_o))
        else $error("state moved while clock enable low");
    a_upper_zero: assert property (dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_boot_target: assert property (boot_target_o == exp_tgt)
        else $error("boot target does not match selector");
    a_slow_hold: assert property (!ack_o |-> $stable({slow_xtal_ampreg_off_o,
        slow_rc_trim_o, slow_rc_on_o, slow_xtal_bias_current_o,
        slow_xtal_bias_resistor_o, slow_xtal_on_o}))
        else $error("slow clock field changed without write");
    a_osc_hold: assert property (!ack_o |-> $stable({fast_xtal_amplitude_o,
        lowfreq_rc_trim_o, boot_map_select_o}))
        else $error("control field changed without write");
    a_link_status: assert property (ack_o && $past(!ack_o && ce_i && cyc_i
        && stb_i && !we_i && adr_i == ADR_STAT) |-> dat_o[9:8] ==
        {$past(link_domain_on_i, 2), $past(link_domain_off_i, 2)})
        else $error("link domain status read wrong");
endmodule : srs_sys_osc_regs_props

bind srs_sys_osc_regs srs_sys_osc_regs_props u_props (.clk_i, .rst_i, .ce_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .link_domain_on_i, .link_domain_off_i,
    .ack_o, .dat_o, .boot_map_select_o, .cache_ram_route_o, .boot_target_o,
    .slow_xtal_ampreg_off_o, .slow_rc_trim_o, .slow_rc_on_o,
    .slow_xtal_bias_current_o, .slow_xtal_bias_resistor_o, .slow_xtal_on_o,
    .fast_xtal_amplitude_o, .lowfreq_rc_trim_o);
